// ---- core/shp_pkg.sv ----
// Constants and types for the two-wire serial host port and display RAMs.
// Assumes a single 40 MHz core clock; the serial clock is sampled, not used.
package shp_pkg;
    localparam int unsigned CORE_CLK_HZ      = 40_000_000;
    localparam logic [5:0]  SLAVE_ADDR_HI    = 6'h1D;
    localparam int unsigned TEXT_DEPTH       = 32;
    localparam int unsigned TEXT_AW          = 5;
    localparam int unsigned ICON_DEPTH       = 16;
    localparam int unsigned ICON_AW          = 4;
    localparam int unsigned SEG_GROUP_W      = 5;
    localparam int unsigned SEG_COUNT        = 80;
    localparam int unsigned CTRL_CHAIN_BIT   = 7;
    localparam int unsigned CTRL_SEL_BIT     = 6;
    localparam int unsigned CTRL_DIR_BIT     = 5;
    localparam int unsigned ICON_BLINK_BIT   = 7;
    localparam int unsigned ICON_ONLY_D4_BIT = 6;
    localparam int unsigned ICON_LEFT_BIT    = 4;
    localparam int unsigned BYTE_BITS        = 8;
    localparam logic [3:0]  ACK_SLOT         = 4'h8;
    localparam int unsigned CMD_W            = 9;
    localparam int unsigned CMD_FIFO_DEPTH   = 16;
    localparam logic [7:0]  BYTE_RESET       = 8'h00;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_ADDR,
        ST_CTRL,
        ST_DATA,
        ST_READ,
        ST_IGNORE
    } shp_state_type;
endpackage

// ---- core/shp_port.sv ----
// Two-wire slave port with command FIFO, text RAM and icon RAM.
// Assumes scl/sda come from pins (resynchronised here) and that the
// command engine and display scan logic run on core_clk_in.

module shp_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              push = in_valid_in & in_ready_out;
    wire              pop  = out_valid_out & out_ready_in;

    // Extra pointer bit tells full from empty without a counter
    assign in_ready_out  = !((wr_ptr[AW] != rd_ptr[AW]) &&
                             (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid_out = (wr_ptr != rd_ptr);
    assign out_data_out  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge core_clk_in)
    begin
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data_in;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

module shp_port (
    input  wire logic                          core_clk_in,
    input  wire logic                          rst_n_in,
    input  wire logic                          scl_in,
    input  wire logic                          sda_in,
    output logic                               sda_out,
    output logic                               sda_oe_out,
    input  wire logic                          addr_strap_pin_in,
    input  wire logic                          serial_port_select_in,
    output logic                               cmd_valid_out,
    input  wire logic                          cmd_ready_in,
    output logic                               cmd_instr_data_sel_out,
    output logic [7:0]                         cmd_byte_out,
    output logic                               ctrl_dir_out,
    input  wire logic [shp_pkg::TEXT_AW-1:0]   read_addr_in,
    output logic                               read_taken_out,
    input  wire logic                          ram_wr_in,
    input  wire logic                          ram_icon_sel_in,
    input  wire logic [shp_pkg::TEXT_AW-1:0]   ram_addr_in,
    input  wire logic [7:0]                    ram_wdata_in,
    input  wire logic                          icon_common_line_in,
    input  wire logic                          segment_blink_enable_in,
    input  wire logic                          blink_phase_in,
    input  wire logic [shp_pkg::TEXT_AW-1:0]   display_shift_in,
    input  wire logic                          scan_line_in,
    input  wire logic [3:0]                    scan_digit_in,
    output logic [7:0]                         text_code_out,
    output logic [shp_pkg::SEG_COUNT-1:0]      segment_out
);
    import shp_pkg::*;

    // Digit position plus shift, modulo 32: both lines share one ring
    function automatic logic [TEXT_AW-1:0] ring_addr(
        input logic                line,
        input logic [3:0]          digit,
        input logic [TEXT_AW-1:0]  shift
    );
        ring_addr = {line, digit} + shift;
    endfunction

    // One icon segment: D4 is the leftmost of the group
    function automatic logic icon_bit(
        input logic [7:0]  word,
        input int unsigned pos,
        input logic        com,
        input logic        be,
        input logic        phase
    );
        logic blank;
        blank = be & phase & word[ICON_BLINK_BIT] &
                (~word[ICON_ONLY_D4_BIT] | (pos == 0));
        icon_bit = com & word[ICON_LEFT_BIT - pos] & ~blank;
    endfunction

    logic [1:0]       scl_sync;
    logic [1:0]       sda_sync;
    logic [1:0]       strap_sync;
    logic [1:0]       sel_sync;
    logic             scl_d;
    logic             sda_d;
    shp_state_type    state;
    logic [3:0]       bit_cnt;
    logic             ack_phase;
    logic [7:0]       shreg;
    logic             drive_low;
    logic             first_rd;
    logic             master_ack;
    logic             chain;
    logic             sel;
    logic [7:0]       text_ram [TEXT_DEPTH];
    logic [7:0]       icon_ram [ICON_DEPTH];
    logic             fifo_in_ready;
    logic [CMD_W-1:0] fifo_head;

    // Serial clock is only ever sampled, never driven
    wire scl_s      = scl_sync[1];
    wire sda_s      = sda_sync[1];
    wire scl_rise   = scl_s & ~scl_d;
    wire scl_fall   = ~scl_s & scl_d;
    wire start_det  = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det   = scl_s & scl_d & ~sda_d & sda_s;
    wire tx_mode    = (state == ST_READ);
    wire ack_enter  = scl_fall & ~ack_phase & (bit_cnt == ACK_SLOT);
    wire ack_leave  = scl_fall & ack_phase;
    wire addr_match = (shreg[7:2] == SLAVE_ADDR_HI) &&
                      (shreg[1] == strap_sync[1]);
    wire data_push  = ack_enter & (state == ST_DATA);
    wire tx_load    = ack_leave & tx_mode & (first_rd | master_ack);
    wire [7:0] rd_byte = text_ram[read_addr_in];

    // Open drain: the pin is only ever pulled low
    assign sda_out    = 1'b0;
    assign sda_oe_out = drive_low;

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            scl_sync   <= 2'h3;
            sda_sync   <= 2'h3;
            strap_sync <= 2'h0;
            sel_sync   <= 2'h0;
            scl_d      <= 1'b1;
            sda_d      <= 1'b1;
        end
        else
        begin
            scl_sync   <= {scl_sync[0], scl_in};
            sda_sync   <= {sda_sync[0], sda_in};
            strap_sync <= {strap_sync[0], addr_strap_pin_in};
            sel_sync   <= {sel_sync[0], serial_port_select_in};
            scl_d      <= scl_sync[1];
            sda_d      <= sda_sync[1];
        end
    end

    // Bit engine; start and stop take priority over clock edges
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state      <= ST_IDLE;
            bit_cnt    <= 4'h0;
            ack_phase  <= 1'b0;
            shreg      <= BYTE_RESET;
            drive_low  <= 1'b0;
            first_rd   <= 1'b0;
            master_ack <= 1'b0;
        end
        else if (!sel_sync[1] || stop_det || start_det)
        begin
            state <= (start_det && sel_sync[1]) ? ST_ADDR : ST_IDLE;
            bit_cnt   <= 4'h0;
            ack_phase <= 1'b0;
            drive_low <= 1'b0;
        end
        else if (scl_rise)
        begin
            if (!ack_phase && bit_cnt < ACK_SLOT)
            begin
                bit_cnt <= bit_cnt + 4'h1;
                if (!tx_mode)
                    shreg <= {shreg[6:0], sda_s};
            end
            if (ack_phase && tx_mode)
                master_ack <= ~sda_s;
        end
        else if (ack_enter)
        begin
            ack_phase <= 1'b1;
            case (state)
                ST_ADDR:
                begin
                    drive_low <= addr_match;
                    first_rd  <= 1'b1;
                    if (!addr_match)
                        state <= ST_IGNORE;
                    else
                        state <= shreg[0] ? ST_READ : ST_CTRL;
                end
                ST_CTRL:
                begin
                    drive_low <= 1'b1;
                    state     <= ST_DATA;
                end
                ST_DATA:
                begin
                    // A full FIFO refuses the byte rather than losing it
                    drive_low <= fifo_in_ready;
                    if (!fifo_in_ready)
                        state <= ST_IGNORE;
                    else if (chain)
                        state <= ST_CTRL;
                end
                ST_READ: drive_low <= 1'b0;
                default: drive_low <= 1'b0;
            endcase
        end
        else if (ack_leave)
        begin
            ack_phase <= 1'b0;
            bit_cnt   <= 4'h0;
            first_rd  <= 1'b0;
            if (tx_load)
            begin
                shreg     <= rd_byte;
                drive_low <= ~rd_byte[7];
            end
            else
            begin
                drive_low <= 1'b0;
                if (tx_mode)
                    state <= ST_IGNORE;
            end
        end
        else if (scl_fall && tx_mode)
        begin
            // Changes only after a falling clock edge
            shreg     <= {shreg[6:0], 1'b0};
            drive_low <= ~shreg[6];
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            chain          <= 1'b0;
            sel            <= 1'b0;
            ctrl_dir_out   <= 1'b0;
            read_taken_out <= 1'b0;
        end
        else
        begin
            read_taken_out <= tx_load & ~start_det & ~stop_det;
            if (ack_enter && state == ST_CTRL)
            begin
                chain        <= shreg[CTRL_CHAIN_BIT];
                sel          <= shreg[CTRL_SEL_BIT];
                ctrl_dir_out <= shreg[CTRL_DIR_BIT];
            end
        end
    end

    shp_fifo #(
        .WIDTH (CMD_W),
        .DEPTH (CMD_FIFO_DEPTH)
    ) cmd_fifo (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (data_push),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    ({sel, shreg}),
        .out_valid_out (cmd_valid_out),
        .out_ready_in  (cmd_ready_in),
        .out_data_out  (fifo_head)
    );

    assign {cmd_instr_data_sel_out, cmd_byte_out} = fifo_head;

    always_ff @(posedge core_clk_in)
    begin
        if (ram_wr_in && ram_icon_sel_in)
            icon_ram[ram_addr_in[ICON_AW-1:0]] <= ram_wdata_in;
        if (ram_wr_in && !ram_icon_sel_in)
            text_ram[ram_addr_in] <= ram_wdata_in;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            text_code_out <= BYTE_RESET;
            segment_out   <= '0;
        end
        else
        begin
            text_code_out <= text_ram[ring_addr(scan_line_in, scan_digit_in,
                                                display_shift_in)];
            for (int g = 0; g < ICON_DEPTH; g++)
            begin
                for (int j = 0; j < SEG_GROUP_W; j++)
                begin
                    segment_out[g*SEG_GROUP_W + j] <=
                        icon_bit(icon_ram[g], j, icon_common_line_in,
                                 segment_blink_enable_in, blink_phase_in);
                end
            end
        end
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_addr_slot;
        ack_enter && state == ST_ADDR;
    endsequence
    sequence s_chained_data;
        ack_enter && state == ST_DATA && fifo_in_ready && chain;
    endsequence

    a_addr_ack_match: assert property (
        s_addr_slot and addr_match |=> sda_oe_out && state != ST_IGNORE)
        else $error("matching address not acknowledged");
    a_addr_mismatch_quiet: assert property (
        s_addr_slot and !addr_match |=> !sda_oe_out && state == ST_IGNORE)
        else $error("mismatched address driven or not ignored");
    a_start_restart: assert property (
        start_det && sel_sync[1] |=> state == ST_ADDR && bit_cnt == 4'h0)
        else $error("start did not restart address wait");
    a_stop_release: assert property (
        stop_det |=> state == ST_IDLE && !sda_oe_out ##1 !sda_oe_out)
        else $error("stop did not release the port");
    a_drive_scl_low: assert property (
        $rose(sda_oe_out) |-> !scl_s)
        else $error("data line pulled while clock high");
    a_chain_ctrl: assert property (
        s_chained_data |=> state == ST_CTRL)
        else $error("chained byte not followed by control wait");
    a_rx_ack_release: assert property (
        ack_leave && !tx_mode |=> !sda_oe_out && bit_cnt == 4'h0)
        else $error("acknowledge not released after ninth clock");
    a_read_nack_stop: assert property (
        ack_leave && tx_mode && !first_rd && !master_ack
        |=> state == ST_IGNORE && !sda_oe_out)
        else $error("read continued after master not-acknowledge");
    a_icon_dark: assert property (
        !icon_common_line_in |=> segment_out == '0)
        else $error("icon segments lit off the icon common");
endmodule

// ---- verif/shp_master_model.sv ----
// Behavioural two-wire bus master for the serial host port bench.
// Assumes an external pull-up on the data wire, resolved by the bench.
module shp_master_model (
    input  wire logic core_clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Clock stands high and still between frames
    initial
    begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end

    // Quarter of a 200 ns serial clock
    task automatic q();
        repeat (2) @(posedge core_clk_in);
    endtask

    // Only the master makes the serial clock
    task automatic bit_io(input logic b, output logic r);
        q();
        sda_oe_out <= ~b; // Data moves only while scl is low
        q();
        scl_out <= 1'b1;
        q();
        r = sda_in;
        q();
        scl_out <= 1'b0;
    endtask

    // Extra quarter lets a device release its ack first
    task automatic start();
        q();
        q();
        sda_oe_out <= 1'b0;
        q();
        scl_out <= 1'b1;
        q();
        sda_oe_out <= 1'b1;
        q();
        scl_out <= 1'b0;
    endtask

    task automatic stop();
        q();
        sda_oe_out <= 1'b1;
        q();
        scl_out <= 1'b1;
        q();
        sda_oe_out <= 1'b0;
        q();
        q();
    endtask

    // Address or control or data byte, MSB first
    task automatic wr_byte(input logic [7:0] d, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, nak); // Released for the receiver's ack
    endtask

    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r); // Ack asks for one more byte
    endtask
endmodule

// ---- verif/shp_port_tb.sv ----
// Self-checking bench for the serial host port and display RAMs.
// Assumes the master model drives the serial side; RAM loads by ports.
`define CHK(a, e) \
    begin \
        total_checks++; \
        if ((a) !== (e)) \
        begin \
            miscompares++; \
            $display("mismatch %0t got %h exp %h", $time, a, e); \
        end \
    end
module shp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import shp_pkg::*;

    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       scl, m_sda_oe, sda_line, sda_o, sda_oe, vld, rdy = 1'b0;
    logic       sel, dir, taken, wr = 1'b0, ic = 1'b0, com = 1'b0;
    logic       be = 1'b0, ph = 1'b0, line = 1'b0, nk, r;
    logic [4:0] rd_addr, rd_step = 5'h00, wa = 5'h00, shift = 5'h00;
    logic       strap = 1'b0;
    logic [3:0] digit = 4'h0;
    logic [7:0] wd = 8'h00, cbyte, tcode, d;
    logic [SEG_COUNT-1:0] seg;
    int         miscompares = 0, total_checks = 0, cycles = 0;
    localparam logic [7:0] AW = {SLAVE_ADDR_HI, 2'b00};

    always #12.5 core_clk = ~core_clk;
    assign sda_line = ~(m_sda_oe | sda_oe); // Pull-up when released

    shp_master_model i_mst (.core_clk_in(core_clk), .sda_in(sda_line),
        .scl_out(scl), .sda_oe_out(m_sda_oe));

    // Strap fixed for a whole frame port select held high
    shp_port i_dut (.core_clk_in(core_clk), .rst_n_in(rst_n),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .addr_strap_pin_in(strap),
        .serial_port_select_in(1'b1), .cmd_valid_out(vld),
        .cmd_ready_in(rdy), .cmd_instr_data_sel_out(sel),
        .cmd_byte_out(cbyte), .ctrl_dir_out(dir), .read_addr_in(rd_addr),
        .read_taken_out(taken), .ram_wr_in(wr), .ram_icon_sel_in(ic),
        .ram_addr_in(wa), .ram_wdata_in(wd), .icon_common_line_in(com),
        .segment_blink_enable_in(be), .blink_phase_in(ph),
        .display_shift_in(shift), .scan_line_in(line),
        .scan_digit_in(digit), .text_code_out(tcode), .segment_out(seg));

    // Reads start at text address 3; each taken byte steps it
    assign rd_addr = 5'h03 + rd_step;
    always @(posedge core_clk)
        if (taken === 1'b1)
            rd_step <= rd_step + 5'h01;

    task automatic close_out();
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            close_out();
        end
    end

    task automatic wb(input logic [7:0] v, input logic exp_nak);
        i_mst.wr_byte(v, nk);
        `CHK(nk, exp_nak)
    endtask

    task automatic ram_write(input logic i, input logic [4:0] a,
                             input logic [7:0] v);
        @(posedge core_clk);
        wr <= 1'b1;
        ic <= i;
        wa <= a;
        wd <= v;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    task automatic pop(input logic [8:0] e);
        int n;
        n = 0;
        while (vld !== 1'b1 && n < 50)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK({sel, cbyte}, e)
        @(posedge core_clk);
        rdy <= 1'b1;
        @(posedge core_clk);
        rdy <= 1'b0;
        #1;
    endtask

    task automatic disp(input logic l, input logic [3:0] g,
                        input logic [4:0] s, input logic [7:0] e);
        @(posedge core_clk);
        line <= l;
        digit <= g;
        shift <= s;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(tcode, e)
    endtask

    // Icon word at location 2 drives segments 10 to 14
    task automatic icon(input logic [7:0] w, input logic c, input logic b,
                        input logic p, input logic [4:0] e);
        ram_write(1'b1, 5'h02, w);
        @(posedge core_clk);
        com <= c;
        be <= b;
        ph <= p;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(seg[14:10], e)
    endtask

    initial
    begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        `CHK(sda_o, 1'b0)
        i_mst.start();
        wb(AW, 1'b0);
        wb(8'h40, 1'b0);
        for (int i = 0; i < 16; i++)
            wb(8'h10 + 8'(i), 1'b0);
        wb(8'hEE, 1'b1); // Full buffer refuses
        i_mst.stop();
        for (int i = 0; i < 16; i++)
            pop({1'b1, 8'h10 + 8'(i)});
        `CHK(vld, 1'b0)
        i_mst.start();
        wb(AW | 8'h02, 1'b1);
        wb(8'h40, 1'b1);
        i_mst.start();
        wb(8'h70, 1'b1);
        i_mst.stop();
        `CHK(vld, 1'b0)
        i_mst.start();
        repeat (4) i_mst.bit_io(1'b1, r);
        i_mst.start();
        wb(AW, 1'b0);
        wb(8'hA0, 1'b0);
        `CHK(dir, 1'b1)
        wb(8'h55, 1'b0);
        wb(8'h40, 1'b0);
        `CHK(dir, 1'b0)
        wb(8'hAA, 1'b0);
        i_mst.stop();
        pop({1'b0, 8'h55});
        pop({1'b1, 8'hAA});
        for (int k = 0; k < 32; k++)
            ram_write(1'b0, 5'(k), 8'h40 + 8'(k));
        i_mst.start();
        wb(AW | 8'h01, 1'b0);
        i_mst.rd_byte(1'b1, d);
        `CHK(d, 8'h43)
        i_mst.rd_byte(1'b0, d);
        `CHK(d, 8'h44)
        i_mst.bit_io(1'b1, r);
        `CHK(r, 1'b1)
        i_mst.stop();
        strap <= 1'b1;
        i_mst.start();
        wb(AW, 1'b1);
        i_mst.start();
        wb(AW | 8'h02, 1'b0);
        wb(8'h00, 1'b0);
        wb(8'h21, 1'b0);
        i_mst.start();
        wb(AW | 8'h02, 1'b0);
        wb(8'h40, 1'b0);
        wb(8'h22, 1'b0);
        i_mst.stop();
        pop({1'b0, 8'h21});
        pop({1'b1, 8'h22});
        disp(1'b0, 4'h0, 5'h00, 8'h40);
        disp(1'b1, 4'hF, 5'h00, 8'h5F);
        disp(1'b0, 4'h0, 5'h1F, 8'h5F);
        disp(1'b1, 4'h0, 5'h1F, 8'h4F);
        disp(1'b0, 4'hF, 5'h01, 8'h50);
        disp(1'b1, 4'hF, 5'h01, 8'h40);
        icon(8'h13, 1'b1, 1'b0, 1'b0, 5'b11001);
        icon(8'h33, 1'b1, 1'b0, 1'b0, 5'b11001);
        icon(8'h13, 1'b0, 1'b0, 1'b0, 5'b00000);
        icon(8'hB3, 1'b1, 1'b1, 1'b1, 5'b00000);
        icon(8'hB3, 1'b1, 1'b1, 1'b0, 5'b11001);
        icon(8'hB3, 1'b1, 1'b0, 1'b1, 5'b11001);
        icon(8'hF3, 1'b1, 1'b1, 1'b1, 5'b11000);
        close_out();
    end
endmodule
